// >>> core/spifx_core.sv
// Serial port core: control/status registers, byte FIFOs, shift engine
// on the serial clock, master clock sequencer and select expander.
// Assumes the SCK pad input returns the driven level in master mode.
`timescale 1ns/1ns
module spifx_core
    import spifx_pkg::*;
#(
    parameter int INSTR_CYCLE_CLOCKS = SPIFX_INSTR_CLOCKS,
    parameter int FIFO_DEPTH = SPIFX_FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [7:0] i_bus_addr,
    input wire logic [7:0] i_bus_wdata,
    input wire logic i_bus_write,
    input wire logic i_bus_read,
    output logic [7:0] o_bus_rdata,
    input wire logic i_link_clock,
    input wire logic i_mosi,
    input wire logic i_miso,
    input wire logic i_ss,
    output logic o_sck,
    output logic o_sck_oe_n,
    output logic o_mosi,
    output logic o_mosi_oe_n,
    output logic o_miso,
    output logic o_miso_oe_n,
    output logic o_ss,
    output logic o_ss_oe_n,
    output logic [7:0] o_expanded_select_out,
    output logic [7:0] o_port_n_expander_select,
    output logic o_rx_irq,
    output logic o_tx_irq,
    output logic o_tx_ready
);
    localparam int HALF_F = (INSTR_CYCLE_CLOCKS * SPIFX_RATE_FAST + 1) / 2;
    localparam int HALF_Q = (INSTR_CYCLE_CLOCKS * SPIFX_RATE_QUARTER) / 2;
    localparam int HALF_S = (INSTR_CYCLE_CLOCKS * SPIFX_RATE_SIXTEENTH) / 2;

    logic [7:0] ctrl;
    logic [7:0] nsel;
    logic [7:0] tx_hold;
    logic hold_valid;
    logic ovr;
    logic flush_flag;
    logic ess_det;
    logic exp_mode;
    logic first_done;
    logic [7:0] expanded_select_out;
    logic [1:0] inflight;
    logic link_clear;
    logic ss_s1, ss_s2, ss_d;
    logic mosi_s1, mosi_s2;
    logic ack_s1, ack_s2, ack_s3;
    logic rx_s1, rx_s2, rx_s3;
    logic sck_drive;
    logic ss_drive;
    spifx_master_type state;
    logic [7:0] half_cnt;
    logic [7:0] half_lim;
    logic [4:0] edges;
    // Link-domain state
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [7:0] rx_byte;
    logic rx_tog;
    logic [7:0] tx_sh;
    logic [2:0] tx_cnt;
    logic fresh;
    logic out_bit;
    logic ack_tog;

    logic en, master, clock_edge_select, loop_on, exp_en;
    logic ss_line, frame_rst, link_clk, in_bit, out_pin, take_now;
    logic [7:0] take_byte;
    logic ss_fall, ss_rise, rx_ev, ack_ev;
    logic ctrl_wr, stat_rd, en_rise, tx_empty, tx_full, rx_empty, tx_flush;

    spifx_stream_if #(.WIDTH(SPIFX_BYTE_BITS)) tx_in ();
    spifx_stream_if #(.WIDTH(SPIFX_BYTE_BITS)) tx_out ();
    spifx_stream_if #(.WIDTH(SPIFX_BYTE_BITS)) rx_in ();
    spifx_stream_if #(.WIDTH(SPIFX_BYTE_BITS)) rx_out ();

    // Control decode
    assign en = ctrl[SPIFX_B_EN];
    assign master = (ctrl[SPIFX_B_MODE +: 2] != SPIFX_MODE_SLAVE);
    assign clock_edge_select = ctrl[SPIFX_B_SCE];
    assign loop_on = ctrl[SPIFX_B_LOOP];
    assign exp_en = ctrl[SPIFX_B_EXPEN];
    assign ctrl_wr = i_bus_write && (i_bus_addr == SPIFX_CTRL_ADDR);
    assign stat_rd = i_bus_read && (i_bus_addr == SPIFX_STAT_ADDR);
    assign en_rise = ctrl_wr && i_bus_wdata[SPIFX_B_EN] && !en;

    // Frame signal and link clock; edge select flips the clock sense
    assign ss_line = master ? ss_drive : i_ss;
    assign frame_rst = ss_line || !en || link_clear;
    assign link_clk = i_link_clock ^ clock_edge_select;
    assign take_byte = hold_valid ? tx_hold : 8'h00;
    assign take_now = (fresh && !clock_edge_select) || (tx_cnt == 3'h0);
    assign out_pin = (fresh && !clock_edge_select) ? take_byte[7] : out_bit;
    assign in_bit = loop_on ? out_pin : (master ? i_miso : i_mosi);

    // Sample edge: shift in one bit, drop partial byte at frame end
    always_ff @(posedge link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            rx_sh <= 8'h00;
            rx_cnt <= 3'h0;
        end else begin
            rx_sh <= {rx_sh[6:0], in_bit};
            rx_cnt <= rx_cnt + 3'h1;
        end
    end

    // Completed byte handed over with a toggle
    always_ff @(posedge link_clk or posedge link_clear) begin
        if (link_clear) begin
            rx_byte <= 8'h00;
            rx_tog <= 1'b0;
        end else if (rx_cnt == 3'(SPIFX_BYTE_BITS - 1)) begin
            rx_byte <= {rx_sh[6:0], in_bit};
            rx_tog <= !rx_tog;
        end
    end

    // Change edge: present next bit, first bit shown early when sce is 0
    always_ff @(negedge link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            tx_sh <= 8'h00;
            tx_cnt <= 3'h0;
            fresh <= 1'b1;
            out_bit <= 1'b0;
        end else begin
            fresh <= 1'b0;
            if (fresh && !clock_edge_select) begin
                out_bit <= take_byte[6];
                tx_sh <= {take_byte[5:0], 2'b00};
                tx_cnt <= 3'h2;
            end else if (tx_cnt == 3'h0) begin
                out_bit <= take_byte[7];
                tx_sh <= {take_byte[6:0], 1'b0};
                tx_cnt <= 3'h1;
            end else begin
                out_bit <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
                tx_cnt <= tx_cnt + 3'h1;
            end
        end
    end

    // Acknowledge each byte taken from the hold register
    always_ff @(negedge link_clk or posedge link_clear) begin
        if (link_clear) begin
            ack_tog <= 1'b0;
        end else if (!frame_rst && take_now && hold_valid) begin
            ack_tog <= !ack_tog;
        end
    end

    // Reset of the link domain, held through system reset
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            link_clear <= 1'b1;
        end else begin
            link_clear <= 1'b0;
        end
    end

    // Synchronisers for pins and link toggles
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            {ss_s1, ss_s2, ss_d} <= 3'b111;
            {mosi_s1, mosi_s2} <= 2'b11;
            {ack_s1, ack_s2, ack_s3} <= 3'b000;
            {rx_s1, rx_s2, rx_s3} <= 3'b000;
        end else begin
            ss_s1 <= ss_line;
            ss_s2 <= ss_s1;
            ss_d <= ss_s2;
            mosi_s1 <= i_mosi;
            mosi_s2 <= mosi_s1;
            ack_s1 <= ack_tog;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
            rx_s1 <= rx_tog;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end
    assign ss_fall = ss_d && !ss_s2;
    assign ss_rise = !ss_d && ss_s2;
    assign rx_ev = rx_s2 ^ rx_s3;
    assign ack_ev = ack_s2 ^ ack_s3;

    // FIFO hookup
    assign tx_in.valid = i_bus_write && (i_bus_addr == SPIFX_TXD_ADDR);
    assign tx_in.data = i_bus_wdata;
    assign tx_out.ready = !hold_valid;
    assign rx_in.valid = rx_ev && !exp_mode;
    assign rx_in.data = rx_byte;
    assign rx_out.ready = i_bus_read && (i_bus_addr == SPIFX_RXD_ADDR);
    assign tx_flush = ss_rise && (!tx_empty || hold_valid || inflight != 2'h0);

    spifx_fifo #(.WIDTH(SPIFX_BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_flush(tx_flush),
        .i_push(tx_in),
        .o_pop(tx_out),
        .o_full(tx_full),
        .o_empty(tx_empty)
    );

    spifx_fifo #(.WIDTH(SPIFX_BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_flush(1'b0),
        .i_push(rx_in),
        .o_pop(rx_out),
        .o_full(),
        .o_empty(rx_empty)
    );

    // Control and select registers
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            ctrl <= SPIFX_CTRL_RESET;
            nsel <= SPIFX_NSEL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl <= i_bus_wdata;
            end
            if (i_bus_write && i_bus_addr == SPIFX_NSEL_ADDR) begin
                nsel <= i_bus_wdata;
            end
        end
    end

    // Hold register feeding the link, and bytes in flight
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            tx_hold <= 8'h00;
            hold_valid <= 1'b0;
            inflight <= 2'h0;
        end else if (tx_flush || ss_fall) begin
            hold_valid <= hold_valid && !tx_flush;
            inflight <= 2'h0;
        end else begin
            if (tx_out.valid && tx_out.ready) begin
                tx_hold <= tx_out.data;
                hold_valid <= 1'b1;
            end else if (ack_ev) begin
                hold_valid <= 1'b0;
            end
            if (ack_ev && !rx_ev) begin
                inflight <= inflight + 2'h1;
            end else if (rx_ev && !ack_ev && inflight != 2'h0) begin
                inflight <= inflight - 2'h1;
            end
        end
    end

    // Status flags; a new event wins over the clear on read
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            ovr <= 1'b0;
            flush_flag <= 1'b0;
        end else begin
            ovr <= (ovr && !stat_rd) || (rx_in.valid && !rx_in.ready);
            flush_flag <= (flush_flag && !stat_rd) || tx_flush;
        end
    end

    // Expander detection and programming
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            exp_mode <= 1'b0;
            first_done <= 1'b0;
            ess_det <= 1'b0;
            expanded_select_out <= SPIFX_ALL_ONES;
        end else if (en_rise) begin
            expanded_select_out <= SPIFX_ALL_ONES;
        end else if (ss_fall) begin
            exp_mode <= exp_en && !mosi_s2;
            first_done <= 1'b0;
        end else if (ss_rise) begin
            exp_mode <= 1'b0;
            ess_det <= 1'b0;
            expanded_select_out <= expanded_select_out | nsel;
        end else if (rx_ev && exp_mode && !first_done) begin
            expanded_select_out <= rx_byte;
            first_done <= 1'b1;
            ess_det <= 1'b1;
        end
    end

    // Port N drive: only selected bits follow the expander
    for (genvar i = 0; i < 8; i++) begin : g_port_n
        always_ff @(posedge i_clock) begin
            if (!i_resetn) begin
                o_expanded_select_out[i] <= 1'b1;
            end else begin
                o_expanded_select_out[i] <= nsel[i] ? expanded_select_out[i] : 1'b1;
            end
        end
    end

    // Master half-period limit per rate code
    always_comb begin
        case (ctrl[SPIFX_B_MODE +: 2])
            SPIFX_MODE_FAST: half_lim = 8'(HALF_F);
            SPIFX_MODE_QUARTER: half_lim = 8'(HALF_Q);
            default: half_lim = 8'(HALF_S);
        endcase
    end

    // Master sequencer: select low, 16 clock edges per byte
    always_ff @(posedge i_clock) begin
        if (!i_resetn || !en || !master) begin
            state <= SPIFX_M_IDLE;
            sck_drive <= 1'b0;
            ss_drive <= 1'b1;
            half_cnt <= 8'h00;
            edges <= 5'h00;
        end else begin
            case (state)
                SPIFX_M_IDLE: begin
                    if (half_cnt != half_lim - 8'h01) begin
                        half_cnt <= half_cnt + 8'h01;
                    end else if (hold_valid) begin
                        ss_drive <= 1'b0;
                        half_cnt <= 8'h00;
                        edges <= 5'h00;
                        state <= SPIFX_M_SHIFT;
                    end
                end
                SPIFX_M_SHIFT: begin
                    if (half_cnt == half_lim - 8'h01) begin
                        half_cnt <= 8'h00;
                        sck_drive <= !sck_drive;
                        edges <= edges + 5'h01;
                        if (edges == SPIFX_LAST_EDGE) begin
                            state <= SPIFX_M_DONE;
                        end
                    end else begin
                        half_cnt <= half_cnt + 8'h01;
                    end
                end
                SPIFX_M_DONE: begin
                    if (half_cnt != half_lim - 8'h01) begin
                        half_cnt <= half_cnt + 8'h01;
                    end else if (hold_valid || inflight != 2'h0) begin
                        half_cnt <= 8'h00;
                        edges <= 5'h00;
                        state <= SPIFX_M_SHIFT;
                    end else begin
                        ss_drive <= 1'b1;
                        half_cnt <= 8'h00;
                        state <= SPIFX_M_IDLE;
                    end
                end
                default: state <= SPIFX_M_IDLE;
            endcase
        end
    end

    // Pin directions, requests, and bus read data
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            {o_sck_oe_n, o_ss_oe_n, o_mosi_oe_n, o_miso_oe_n} <= 4'hf;
            o_rx_irq <= 1'b0;
            o_tx_irq <= 1'b0;
            o_tx_ready <= 1'b0;
            o_bus_rdata <= 8'h00;
        end else begin
            o_sck_oe_n <= !(en && master);
            o_ss_oe_n <= !(en && master);
            o_mosi_oe_n <= !(en && master);
            o_miso_oe_n <= !(en && !master);
            o_rx_irq <= ctrl[SPIFX_B_RXIE] && (!rx_empty || ovr);
            o_tx_irq <= ctrl[SPIFX_B_TXIE] && tx_empty;
            o_tx_ready <= !tx_full;
            if (i_bus_read) begin
                case (i_bus_addr)
                    SPIFX_CTRL_ADDR: o_bus_rdata <= ctrl;
                    SPIFX_STAT_ADDR: o_bus_rdata <= {ovr, !rx_empty, tx_full, tx_empty,
                        flush_flag, ess_det, 2'b00};
                    SPIFX_RXD_ADDR: o_bus_rdata <= rx_out.valid ? rx_out.data : 8'h00;
                    SPIFX_NSEL_ADDR: o_bus_rdata <= nsel;
                    default: o_bus_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Pin outputs
    assign o_sck = sck_drive;
    assign o_ss = ss_drive;
    assign o_mosi = out_pin;
    assign o_miso = out_pin;
    assign o_port_n_expander_select = nsel;

    ctrl_reset_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $rose(i_resetn) |-> ctrl == SPIFX_CTRL_RESET && !o_rx_irq && o_sck_oe_n)
        else $error("control not cleared by reset");
    exp_detect_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ss_fall && !en_rise |=> exp_mode == $past(exp_en && !mosi_s2))
        else $error("expander detection wrong at select fall");
    exp_program_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        rx_ev && exp_mode && !first_done && !ss_fall && !ss_rise && !en_rise
        |=> expanded_select_out == $past(rx_byte) ##2 o_expanded_select_out == (expanded_select_out | ~nsel))
        else $error("first byte not on port N");
    exp_discard_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        exp_mode && first_done && rx_ev && !ss_rise && !en_rise
        |=> $stable(expanded_select_out) && !$past(rx_in.valid))
        else $error("byte after expander byte not dropped");
    exp_release_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ss_rise && !en_rise |=> (expanded_select_out & nsel) == nsel)
        else $error("selected port N bits not high after frame");
    enable_force_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        en_rise |=> expanded_select_out == SPIFX_ALL_ONES ##1 o_expanded_select_out == SPIFX_ALL_ONES)
        else $error("enable did not force expander outputs high");
    overrun_set_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        rx_in.valid && !rx_in.ready |=> ovr ##1 (ovr || $past(stat_rd)))
        else $error("overrun not flagged");
    flush_ptrs_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ss_rise && !tx_empty && !tx_in.valid |=> flush_flag && tx_empty && !hold_valid)
        else $error("early frame end did not flush");
    rate_step_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        state == SPIFX_M_SHIFT && $changed(sck_drive) |-> $past(half_cnt) == half_lim - 8'h01)
        else $error("master clock half period wrong");
    slave_pins_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        en && !master ##1 $stable(ctrl) |-> o_sck_oe_n && o_ss_oe_n && !o_miso_oe_n)
        else $error("slave pin directions wrong");
    irq_gate_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        !ctrl[SPIFX_B_RXIE] && !ctrl[SPIFX_B_TXIE] |=> !o_rx_irq && !o_tx_irq)
        else $error("request raised while disabled");
endmodule

// >>> core/spifx_fifo.sv
// Synchronous byte FIFO with flush, valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ns
module spifx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 12
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_flush,
    spifx_stream_if.sink i_push,
    spifx_stream_if.source o_pop,
    output logic o_full,
    output logic o_empty
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    // Handshake and level flags
    assign o_full = (count == (AW+1)'(DEPTH));
    assign o_empty = (count == '0);
    assign i_push.ready = !o_full;
    assign o_pop.valid = !o_empty;
    assign o_pop.data = mem[rd_ptr];
    assign do_push = i_push.valid && !o_full;
    assign do_pop = o_pop.ready && !o_empty;

    // Pointers and fill count; flush empties at once
    always_ff @(posedge i_clock) begin
        if (!i_resetn || i_flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end

    // Storage
    always_ff @(posedge i_clock) begin
        if (do_push) begin
            mem[wr_ptr] <= i_push.data;
        end
    end

    fill_bound_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
        do_push && count == (AW+1)'(DEPTH - 1) && !do_pop |=> o_full && !i_push.ready)
        else $error("fifo did not report full at its depth");
endmodule

// >>> pkg/spifx_pkg.sv
// Shared constants for the serial port with FIFOs and select expander.
// Assumes an 8-bit internal register bus and an 8-bit serial byte.
package spifx_pkg;
    // Register addresses on the internal bus
    localparam logic [7:0] SPIFX_CTRL_ADDR = 8'h98;
    localparam logic [7:0] SPIFX_STAT_ADDR = 8'h99;
    localparam logic [7:0] SPIFX_TXD_ADDR = 8'h9a;
    localparam logic [7:0] SPIFX_RXD_ADDR = 8'h9b;
    localparam logic [7:0] SPIFX_NSEL_ADDR = 8'h9c;
    localparam logic [7:0] SPIFX_CTRL_RESET = 8'h00;
    localparam logic [7:0] SPIFX_NSEL_RESET = 8'h00;
    localparam logic [7:0] SPIFX_ALL_ONES = 8'hff;
    // Control field positions
    localparam int SPIFX_B_RXIE = 7;
    localparam int SPIFX_B_TXIE = 6;
    localparam int SPIFX_B_EXPEN = 5;
    localparam int SPIFX_B_MODE = 3;
    localparam int SPIFX_B_SCE = 2;
    localparam int SPIFX_B_EN = 1;
    localparam int SPIFX_B_LOOP = 0;
    // Operation mode codes
    localparam logic [1:0] SPIFX_MODE_SLAVE = 2'h0;
    localparam logic [1:0] SPIFX_MODE_FAST = 2'h1;
    localparam logic [1:0] SPIFX_MODE_QUARTER = 2'h2;
    // Master clock dividers in instruction cycles, and clocks per instruction cycle
    localparam int SPIFX_RATE_FAST = 1;
    localparam int SPIFX_RATE_QUARTER = 4;
    localparam int SPIFX_RATE_SIXTEENTH = 16;
    localparam int SPIFX_INSTR_CLOCKS = 10;
    // Byte and buffer sizes
    localparam int SPIFX_BYTE_BITS = 8;
    localparam int SPIFX_FIFO_DEPTH = 12;
    localparam logic [4:0] SPIFX_LAST_EDGE = 5'h0f;
    // Master sequencer states
    typedef enum logic [1:0] {
        SPIFX_M_IDLE = 2'b00,
        SPIFX_M_SHIFT = 2'b01,
        SPIFX_M_DONE = 2'b11
    } spifx_master_type;
endpackage

// >>> pkg/spifx_stream_if.sv
// Valid/ready byte stream between the serial core and its FIFOs.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface spifx_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source(output valid, output data, input ready);
    modport sink(input valid, input data, output ready);
endinterface

// >>> verif/spi_fifo_ss_expander_tb.sv
// Self-checking bench: slave transfer, flush, select expander, master loop-back.
// Assumes the master model drives the link side.
`timescale 1ns/1ns
module spi_fifo_ss_expander_tb;
    import spifx_pkg::*;
    logic i_clock, i_resetn, i_bus_write, i_bus_read;
    logic [7:0] i_bus_addr, i_bus_wdata, o_bus_rdata, o_expanded_select_out, rd, nsel_out;
    logic [15:0] rx;
    logic sck, ss_n, mosi, miso, miso_oe_n;
    logic dut_sck, sck_oe_n, rx_irq, tx_irq, tx_ready;
    int n_mismatch = 0, samples_checked = 0, cycles = 0;
    spifx_core #(.INSTR_CYCLE_CLOCKS(2)) i_dut (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata), .i_bus_write(i_bus_write),
        .i_bus_read(i_bus_read), .o_bus_rdata(o_bus_rdata),
        .i_link_clock(sck_oe_n ? sck : dut_sck), // Master drives its own link clock
        .i_mosi(mosi), .i_miso(1'b1), .i_ss(ss_n), .o_sck(dut_sck), .o_sck_oe_n(sck_oe_n),
        .o_mosi(), .o_mosi_oe_n(), .o_miso(miso), .o_miso_oe_n(miso_oe_n), .o_ss(),
        .o_ss_oe_n(), .o_expanded_select_out(o_expanded_select_out),
        .o_port_n_expander_select(nsel_out), .o_rx_irq(rx_irq), .o_tx_irq(tx_irq),
        .o_tx_ready(tx_ready));
    spifx_master_model i_master (.i_miso(miso_oe_n ? 1'b1 : miso), .o_sck(sck),
        .o_ss_n(ss_n), .o_mosi(mosi));
    // System clock
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // Cut a hang short
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One register write or read; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_bus_write <= w;
        i_bus_read <= !w;
        i_bus_addr <= a;
        i_bus_wdata <= d;
        @(posedge i_clock);
        i_bus_write <= 1'b0;
        i_bus_read <= 1'b0;
        @(posedge i_clock);
        #1 rd = o_bus_rdata;
    endtask
    task automatic t_reset();
        bus(1'b0, SPIFX_CTRL_ADDR, 8'h00);
        chk("control", 8'h00, rd);
        chk("tx ready", 8'h01, {7'h00, tx_ready});
        $display("reset test done");
    endtask
    task automatic t_slave();
        bus(1'b1, SPIFX_CTRL_ADDR, 8'h02);
        chk("select out", 8'hff, o_expanded_select_out);
        bus(1'b1, SPIFX_TXD_ADDR, 8'h3c);
        bus(1'b1, SPIFX_TXD_ADDR, 8'h11);
        bus(1'b1, SPIFX_TXD_ADDR, 8'h22);
        bus(1'b1, SPIFX_TXD_ADDR, 8'h33);
        i_master.frame(16'ha500, 8, 1'b0, rx);
        repeat (10) @(posedge i_clock);
        chk("miso byte", 8'h3c, rx[7:0]);
        bus(1'b0, SPIFX_STAT_ADDR, 8'h00);
        chk("flush flag", 8'h08, rd & 8'h08);
        bus(1'b0, SPIFX_RXD_ADDR, 8'h00);
        chk("rx byte", 8'ha5, rd);
        $display("slave test done");
    endtask
    task automatic t_expander();
        bus(1'b1, SPIFX_NSEL_ADDR, 8'h0f);
        chk("port select", 8'h0f, nsel_out);
        bus(1'b1, SPIFX_CTRL_ADDR, 8'h22);
        i_master.frame(16'h0577, 16, 1'b1, rx);
        repeat (10) @(posedge i_clock);
        chk("select in frame", 8'hf5, o_expanded_select_out);
        i_master.end_frame();
        repeat (10) @(posedge i_clock);
        chk("select after frame", 8'hff, o_expanded_select_out);
        bus(1'b0, SPIFX_RXD_ADDR, 8'h00);
        chk("rx after expander", 8'h00, rd);
        bus(1'b1, SPIFX_NSEL_ADDR, 8'hff);
        chk("select widened", 8'h0f, o_expanded_select_out);
        bus(1'b1, SPIFX_CTRL_ADDR, 8'h00);
        bus(1'b1, SPIFX_CTRL_ADDR, 8'h22);
        chk("select forced", 8'hff, o_expanded_select_out);
        $display("expander test done");
    endtask
    task automatic t_master();
        bus(1'b1, SPIFX_CTRL_ADDR, 8'h5b);
        bus(1'b1, SPIFX_TXD_ADDR, 8'hc3);
        repeat (400) @(posedge i_clock);
        chk("sck drive", 8'h00, {7'h00, sck_oe_n});
        chk("irq lines", 8'h01, {6'h00, rx_irq, tx_irq});
        bus(1'b0, SPIFX_RXD_ADDR, 8'h00);
        chk("loop byte", 8'hc3, rd);
        $display("master test done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial begin
        i_resetn = 1'b0;
        i_bus_write = 1'b0;
        i_bus_read = 1'b0;
        i_bus_addr = 8'h00;
        i_bus_wdata = 8'h00;
        repeat (5) @(posedge i_clock);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clock);
        t_reset();
        t_slave();
        t_expander();
        t_master();
        results();
    end
endmodule

// >>> verif/spifx_master_model.sv
// Link-side master model: select and a 125 ns serial clock within frames.
// Assumes the device is a slave with clock edge select at zero.
`timescale 1ns/1ns
module spifx_master_model (
    input wire logic i_miso,
    output logic o_sck,
    output logic o_ss_n,
    output logic o_mosi
);
    // Idle: clock low, select high outside frames
    initial begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
        o_mosi = 1'b1;
    end
    // Change data on the falling edge, sample on the rising edge
    task automatic frame(input logic [15:0] tx, input int n, input logic keep,
        output logic [15:0] rx);
        rx = '0;
        o_mosi = tx[15];
        #200 o_ss_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #62 o_sck = 1'b1;
            rx = {rx[14:0], i_miso};
            #63 o_sck = 1'b0;
            tx = tx << 1;
            o_mosi = tx[15];
        end
        if (!keep) begin
            end_frame();
        end
    endtask
    // Released data line moves away from its last value
    task automatic end_frame();
        #200 o_ss_n = 1'b1;
        o_mosi = ~o_mosi;
    endtask
endmodule
